// >>> verilog/adc_seq_defs.vh
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// Register offsets
`define OFS_CONV_MAIN      8'h00
`define OFS_ACCUM_CTRL     8'h01
`define OFS_REF_CLK_CTRL   8'h02
`define OFS_DELAY_CTRL     8'h03
`define OFS_WINDOW_CTRL    8'h04
`define OFS_SAMPLE_LENGTH_CTRL   8'h05
`define OFS_INPUT_SEL      8'h06
`define OFS_COMMAND        8'h08
`define OFS_FLAGS          8'h0B
`define OFS_RESULT_LO      8'h10
`define OFS_RESULT_HI      8'h11
`define OFS_WIN_LOW_LO     8'h12
`define OFS_WIN_LOW_HI     8'h13
`define OFS_WIN_HIGH_LO    8'h14
`define OFS_WIN_HIGH_HI    8'h15

// Writable bit masks
`define MASK_CONV_MAIN     8'h87
`define MASK_ACCUM_CTRL    8'h07
`define MASK_REF_CLK_CTRL  8'h77
`define MASK_DELAY_CTRL    8'hFF
`define MASK_WINDOW_CTRL   8'h07
`define MASK_SAMPLE_LENGTH_CTRL  8'h1F
`define MASK_INPUT_SEL     8'h1F

// Reset values
`define RST_CTRL8          8'h00
`define RST_WORD16         16'h0000

// Field positions
`define BIT_ENABLE         0
`define BIT_CONT_CONV      1
`define BIT_RES_SELECT     2
`define BIT_RUN_STANDBY    7
`define BIT_SAMPLE_CAP     6
`define BIT_AUTO_DLY_VAR   4
`define BIT_START_CMD      0
`define BIT_RESULT_READY   0
`define BIT_WINDOW_MATCH   1
`define FLD_ACCUM_COUNT    2:0
`define FLD_REF_SELECT     5:4
`define FLD_CLK_DIV_SEL    2:0
`define FLD_STARTUP_DLY    7:5
`define FLD_INTER_DLY      3:0
`define FLD_WINDOW_MODE    2:0
`define FLD_SAMPLE_LEN     4:0
`define FLD_INPUT_SEL      4:0

// Encodings
`define REF_INTERNAL       2'h0
`define WIN_NONE           3'h0
`define WIN_BELOW          3'h1
`define WIN_ABOVE          3'h2
`define WIN_INSIDE         3'h3
`define WIN_OUTSIDE        3'h4
`define ACCUM_MAX_CODE     3'h6
`define STARTUP_MAX_CODE   3'h5

// Timing counts in converter-clock cycles
`define SAMPLE_BASE_TICKS  10'h002
`define STARTUP_BASE_TICKS 10'h010

`endif

// >>> verilog/clock_prescaler.v
`timescale 1ns/1ps
// Peripheral clock divider, 2 to 256
module clock_prescaler #(
  parameter WIDTH = 8
) (
  input  wire             clock_in,    // Peripheral clock
  input  wire             reset_n_in,  // Synchronous reset, active low
  input  wire             run_in,      // Divider runs while high
  input  wire [2:0]       div_sel_in,  // Divide by 2^(code+1)
  output reg              tick_out,    // One-cycle converter tick
  output reg              level_out    // Converter clock level
);

  reg  [WIDTH-1:0] cnt_ff;
  wire [WIDTH-1:0] terminal;

  // Terminal count is 2^(code+1)-1
  assign terminal = ~({WIDTH{1'b1}} << (div_sel_in + 4'h1));

  // Counter restarts while converter is off
  always @(posedge clock_in) begin
    if (!reset_n_in || !run_in) begin
      cnt_ff    <= {WIDTH{1'b0}};
      tick_out  <= 1'b0;
      level_out <= 1'b0;
    end else begin
      tick_out  <= (cnt_ff == terminal); // R10
      level_out <= cnt_ff[div_sel_in];
      if (cnt_ff == terminal) begin
        cnt_ff <= {WIDTH{1'b0}};
      end else begin
        cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // clock_prescaler

// >>> verilog/sample_accumulator.v
`timescale 1ns/1ps
`include "adc_seq_defs.vh"
// 16-bit running sample total
module sample_accumulator (
  input  wire        clock_in,     // Peripheral clock
  input  wire        reset_n_in,   // Synchronous reset, active low
  input  wire        clear_in,     // Restart the running total
  input  wire        add_in,       // Fold the sample into the total
  input  wire        res8_in,      // Keep only the eight upper bits
  input  wire [9:0]  sample_in,    // Raw converter result
  output wire [15:0] sum_out,      // Running total plus this sample
  output reg  [15:0] total_out     // Running total
);

  wire [15:0] scaled;

  // 8-bit mode drops two lowest bits
  assign scaled  = res8_in ? {8'h00, sample_in[9:2]} : {6'h00, sample_in}; // R02
  assign sum_out = total_out + scaled; // R07

  // Running total
  always @(posedge clock_in) begin
    if (!reset_n_in || clear_in) begin
      total_out <= `RST_WORD16;
    end else if (add_in) begin
      total_out <= sum_out;
    end
  end

endmodule // sample_accumulator

// >>> verilog/adc_sequencing_control.v
`timescale 1ns/1ps
`include "adc_seq_defs.vh"

// Notes on behaviour
// (R01) Bit 7 keeps the converter running while standby is requested.
// (R02) Resolution bit set drops the two lowest result bits before storing.
// (R03) Continuous mode: first conversion on start write, then back to back.
// (R04) Each completed continuous conversion raises the result-ready flag.
// (R05) Bit 0 enables the converter; zero disables it.
// (R06) Accumulation code 0 none, 1..6 mean 2..64 samples, 7 reserved.
// (R07) Accumulated samples sum into the result as one conversion.
// (R08) Bit 6 selects normal or reduced sampling capacitance.
// (R09) Reference code 0 internal, 1 supply, 2 external pin.
// (R10) Prescaler divides peripheral clock by 2 up to 256.
// (R11) Startup delay of 0..256 converter cycles after enable or internal reference.
// (R12) Startup delay also applies after deep-sleep wake.
// (R13) Auto variation increments the inter-sample delay after each sample.
// (R14) Auto-varied delay wraps from 0xF to 0x0.
// (R15) Inter-sample delay equals the 4-bit field in converter cycles.
// (R16) Sampling switch stays open during the inter-sample delay.
// (R17) Window mode picks below, above, inside or outside for the match flag.
// (R18) Window compare uses 16-bit result against 16-bit thresholds.
// (R19) Sampling lasts two converter cycles by default, lengthened by field.
// (R20) Sampling lasts two plus sample length converter cycles.
// (R21) Input select changes apply only from the next conversion.
// (R22) Start command reads one while busy and clears at completion.
// (R23) Result-ready set on new result; cleared by write one or result read.
module adc_sequencing_control (
  input  wire        clock_in,          // Peripheral clock
  input  wire        reset_n_in,        // Synchronous reset, active low
  input  wire [7:0]  addr_in,           // Register address
  input  wire [7:0]  wr_data_in,        // Write data
  input  wire        wr_en_in,          // Write strobe
  input  wire        rd_en_in,          // Read strobe
  output reg  [7:0]  rd_data_out,       // Read data, one cycle later
  input  wire        standby_req_in,    // Chip standby request pin
  input  wire        deep_wake_in,      // Deep-sleep wake pin
  input  wire        core_done_in,      // Analog core finished a conversion
  input  wire [9:0]  core_result_in,    // Analog core raw result
  output wire        converter_on_out,  // Analog core powered
  output wire        adc_clock_out,     // Converter clock level
  output reg         sample_switch_out, // Sampling switch closed
  output reg         convert_start_out, // Start conversion pulse to core
  output reg  [4:0]  input_select_out,  // Latched analog input
  output wire [1:0]  reference_out,     // Reference source
  output wire        sample_cap_out,    // Reduced sampling capacitance
  output reg         result_event_out,  // One-cycle result-ready pulse
  output wire        result_ready_out,  // Result-ready flag level
  output wire        window_match_out   // Window match flag level
);

  localparam ST_IDLE   = 3'h0;
  localparam ST_INIT   = 3'h1;
  localparam ST_SAMPLE = 3'h2;
  localparam ST_CONV   = 3'h3;
  localparam ST_GAP    = 3'h4;

  reg  [7:0]  conv_main_ff;
  reg  [7:0]  accum_ctrl_ff;
  reg  [7:0]  ref_clk_ctrl_ff;
  reg  [7:0]  delay_ctrl_ff;
  reg  [7:0]  window_ctrl_ff;
  reg  [7:0]  sample_length_ctrl_ff;
  reg  [7:0]  input_sel_ff;
  reg  [15:0] win_low_ff;
  reg  [15:0] win_high_ff;
  reg  [15:0] result_ff;
  reg         ready_flag_ff;
  reg         match_flag_ff;
  reg         busy_ff;
  reg  [2:0]  state_ff;
  reg  [9:0]  phase_ff;
  reg  [9:0]  limit_ff;
  reg  [6:0]  samp_cnt_ff;
  reg         init_pend_ff;
  reg         stby_s1_ff;
  reg         stby_s2_ff;
  reg         wake_s1_ff;
  reg         wake_s2_ff;
  reg         wake_s3_ff;
  reg         nxt_ready;
  reg         nxt_match;
  reg  [7:0]  nxt_rd_data;

  wire        tick;
  wire [15:0] acc_sum;
  wire [15:0] acc_total;
  wire        enable_bit;
  wire        cont_conv;
  wire        active;
  wire        wake_rise;
  wire        start_req;
  wire        final_done;
  wire        acc_add;
  wire        acc_clear;
  wire        result_read;
  wire        wr_main;
  wire        wr_ref;
  wire        wr_delay;
  wire        wr_flags;
  wire [6:0]  samples_needed;

  // Samples per conversion
  function [6:0] sample_total;
    input [2:0] code;
    begin
      if (code > `ACCUM_MAX_CODE) begin
        sample_total = 7'h01;
      end else begin
        sample_total = 7'h01 << code;
      end
    end
  endfunction

  // Startup delay ticks
  function [9:0] startup_ticks;
    input [2:0] code;
    begin
      if (code == 3'h0 || code > `STARTUP_MAX_CODE) begin
        startup_ticks = 10'h000;
      end else begin
        startup_ticks = `STARTUP_BASE_TICKS << (code - 3'h1);
      end
    end
  endfunction

  // Window condition
  function win_hit;
    input [2:0]  mode;
    input [15:0] res;
    input [15:0] lo;
    input [15:0] hi;
    begin
      case (mode)
        `WIN_BELOW:   win_hit = (res < lo);
        `WIN_ABOVE:   win_hit = (res > hi);
        `WIN_INSIDE:  win_hit = (res > lo) && (res < hi);
        `WIN_OUTSIDE: win_hit = (res < lo) || (res > hi);
        default:      win_hit = 1'b0;
      endcase
    end
  endfunction

  // Decoded controls
  assign enable_bit       = conv_main_ff[`BIT_ENABLE];
  assign cont_conv        = conv_main_ff[`BIT_CONT_CONV];
  assign active           = enable_bit && (!stby_s2_ff || conv_main_ff[`BIT_RUN_STANDBY]); // R01 R05
  assign converter_on_out = active;
  assign reference_out    = ref_clk_ctrl_ff[`FLD_REF_SELECT]; // R09
  assign sample_cap_out   = ref_clk_ctrl_ff[`BIT_SAMPLE_CAP]; // R08
  assign result_ready_out = ready_flag_ff;
  assign window_match_out = match_flag_ff;
  assign samples_needed   = sample_total(accum_ctrl_ff[`FLD_ACCUM_COUNT]); // R06
  assign wake_rise        = wake_s2_ff && !wake_s3_ff;

  // Bus decode
  assign wr_main     = wr_en_in && (addr_in == `OFS_CONV_MAIN);
  assign wr_ref      = wr_en_in && (addr_in == `OFS_REF_CLK_CTRL);
  assign wr_delay    = wr_en_in && (addr_in == `OFS_DELAY_CTRL);
  assign wr_flags    = wr_en_in && (addr_in == `OFS_FLAGS);
  assign result_read = rd_en_in && ((addr_in == `OFS_RESULT_LO) || (addr_in == `OFS_RESULT_HI));
  assign start_req   = wr_en_in && (addr_in == `OFS_COMMAND) && wr_data_in[`BIT_START_CMD]
                       && active && (state_ff == ST_IDLE); // R03

  // Sequencer events
  assign final_done = (state_ff == ST_CONV) && core_done_in && (samp_cnt_ff == samples_needed - 7'h01);
  assign acc_add    = (state_ff == ST_CONV) && core_done_in && !final_done;
  assign acc_clear  = final_done || !active || start_req;

  // Clock divider
  clock_prescaler #(
    .WIDTH (8)
  ) u_prescaler (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .run_in     (active),
    .div_sel_in (ref_clk_ctrl_ff[`FLD_CLK_DIV_SEL]),
    .tick_out   (tick),
    .level_out  (adc_clock_out)
  );

  // Accumulator
  sample_accumulator u_accum (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .clear_in   (acc_clear),
    .add_in     (acc_add),
    .res8_in    (conv_main_ff[`BIT_RES_SELECT]),
    .sample_in  (core_result_in),
    .sum_out    (acc_sum),
    .total_out  (acc_total)
  );

  // Pin synchronisers
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      stby_s1_ff <= 1'b0;
      stby_s2_ff <= 1'b0;
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
      wake_s3_ff <= 1'b0;
    end else begin
      stby_s1_ff <= standby_req_in;
      stby_s2_ff <= stby_s1_ff;
      wake_s1_ff <= deep_wake_in;
      wake_s2_ff <= wake_s1_ff;
      wake_s3_ff <= wake_s2_ff;
    end
  end

  // Register writes, delay auto-variation
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      conv_main_ff    <= `RST_CTRL8;
      accum_ctrl_ff   <= `RST_CTRL8;
      ref_clk_ctrl_ff <= `RST_CTRL8;
      delay_ctrl_ff   <= `RST_CTRL8;
      window_ctrl_ff  <= `RST_CTRL8;
      sample_length_ctrl_ff <= `RST_CTRL8;
      input_sel_ff    <= `RST_CTRL8;
      win_low_ff      <= `RST_WORD16;
      win_high_ff     <= `RST_WORD16;
    end else begin
      if (wr_main) begin
        conv_main_ff <= wr_data_in & `MASK_CONV_MAIN;
      end
      if (wr_en_in && addr_in == `OFS_ACCUM_CTRL) begin
        accum_ctrl_ff <= wr_data_in & `MASK_ACCUM_CTRL;
      end
      if (wr_ref) begin
        ref_clk_ctrl_ff <= wr_data_in & `MASK_REF_CLK_CTRL;
      end
      if (wr_delay) begin
        delay_ctrl_ff <= wr_data_in & `MASK_DELAY_CTRL;
      end else if (state_ff == ST_CONV && core_done_in && delay_ctrl_ff[`BIT_AUTO_DLY_VAR]) begin
        // Four-bit add wraps 0xF to 0x0
        delay_ctrl_ff[`FLD_INTER_DLY] <= delay_ctrl_ff[`FLD_INTER_DLY] + 4'h1; // R13 R14
      end
      if (wr_en_in && addr_in == `OFS_WINDOW_CTRL) begin
        window_ctrl_ff <= wr_data_in & `MASK_WINDOW_CTRL;
      end
      if (wr_en_in && addr_in == `OFS_SAMPLE_LENGTH_CTRL) begin
        sample_length_ctrl_ff <= wr_data_in & `MASK_SAMPLE_LENGTH_CTRL;
      end
      if (wr_en_in && addr_in == `OFS_INPUT_SEL) begin
        input_sel_ff <= wr_data_in & `MASK_INPUT_SEL;
      end
      if (wr_en_in && addr_in == `OFS_WIN_LOW_LO) begin
        win_low_ff[7:0] <= wr_data_in;
      end
      if (wr_en_in && addr_in == `OFS_WIN_LOW_HI) begin
        win_low_ff[15:8] <= wr_data_in;
      end
      if (wr_en_in && addr_in == `OFS_WIN_HIGH_LO) begin
        win_high_ff[7:0] <= wr_data_in;
      end
      if (wr_en_in && addr_in == `OFS_WIN_HIGH_HI) begin
        win_high_ff[15:8] <= wr_data_in;
      end
    end
  end

  // Startup delay request
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      init_pend_ff <= 1'b0;
    end else if ((wr_main && wr_data_in[`BIT_ENABLE] && !enable_bit) // R11
                 || (wr_ref && wr_data_in[5:4] == `REF_INTERNAL
                     && ref_clk_ctrl_ff[`FLD_REF_SELECT] != `REF_INTERNAL)
                 || wake_rise) begin // R12
      init_pend_ff <= 1'b1;
    end else if (state_ff == ST_INIT) begin
      init_pend_ff <= 1'b0;
    end
  end

  // Conversion sequencer
  always @(posedge clock_in) begin
    if (!reset_n_in || !active) begin
      state_ff          <= ST_IDLE;
      busy_ff           <= 1'b0;
      phase_ff          <= 10'h000;
      limit_ff          <= 10'h000;
      samp_cnt_ff       <= 7'h00;
      sample_switch_out <= 1'b0;
      convert_start_out <= 1'b0;
      if (!reset_n_in) begin
        input_select_out <= 5'h00;
        result_ff        <= `RST_WORD16;
        result_event_out <= 1'b0;
      end
    end else begin
      convert_start_out <= 1'b0;
      result_event_out  <= 1'b0;
      phase_ff          <= tick ? phase_ff + 10'h001 : phase_ff;
      case (state_ff)
        ST_IDLE: begin
          if (start_req) begin
            busy_ff          <= 1'b1; // R22
            samp_cnt_ff      <= 7'h00;
            input_select_out <= input_sel_ff[`FLD_INPUT_SEL]; // R21
            phase_ff         <= 10'h000;
            if (init_pend_ff && startup_ticks(delay_ctrl_ff[`FLD_STARTUP_DLY]) != 10'h000) begin
              state_ff <= ST_INIT;
              limit_ff <= startup_ticks(delay_ctrl_ff[`FLD_STARTUP_DLY]); // R11
            end else begin
              state_ff          <= ST_SAMPLE;
              sample_switch_out <= 1'b1;
              limit_ff          <= `SAMPLE_BASE_TICKS + {5'h00, sample_length_ctrl_ff[`FLD_SAMPLE_LEN]}; // R19 R20
            end
          end
        end
        ST_INIT, ST_GAP: begin
          if (tick && phase_ff == limit_ff - 10'h001) begin
            state_ff          <= ST_SAMPLE;
            sample_switch_out <= 1'b1;
            phase_ff          <= 10'h000;
            limit_ff          <= `SAMPLE_BASE_TICKS + {5'h00, sample_length_ctrl_ff[`FLD_SAMPLE_LEN]}; // R20
          end
        end
        ST_SAMPLE: begin
          if (tick && phase_ff == limit_ff - 10'h001) begin
            state_ff          <= ST_CONV;
            sample_switch_out <= 1'b0;
            convert_start_out <= 1'b1;
          end
        end
        ST_CONV: begin
          if (core_done_in) begin
            phase_ff <= 10'h000;
            limit_ff <= {6'h00, delay_ctrl_ff[`FLD_INTER_DLY]}; // R15
            if (final_done) begin
              result_ff        <= acc_sum; // R07
              result_event_out <= 1'b1;
              samp_cnt_ff      <= 7'h00;
              input_select_out <= input_sel_ff[`FLD_INPUT_SEL]; // R21
            end else begin
              samp_cnt_ff <= samp_cnt_ff + 7'h01;
            end
            if (final_done && !cont_conv) begin
              state_ff <= ST_IDLE;
              busy_ff  <= 1'b0; // R22
            end else if (delay_ctrl_ff[`FLD_INTER_DLY] != 4'h0) begin
              state_ff <= ST_GAP; // R16
            end else begin
              // No delay: sample at once
              state_ff          <= ST_SAMPLE; // R03
              sample_switch_out <= 1'b1;
              limit_ff          <= `SAMPLE_BASE_TICKS + {5'h00, sample_length_ctrl_ff[`FLD_SAMPLE_LEN]};
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Flags: set beats clear
  always @* begin
    nxt_ready = ready_flag_ff;
    nxt_match = match_flag_ff;
    if (result_read || (wr_flags && wr_data_in[`BIT_RESULT_READY])) begin
      nxt_ready = 1'b0; // R23
    end
    if (result_read || (wr_flags && wr_data_in[`BIT_WINDOW_MATCH])) begin
      nxt_match = 1'b0;
    end
    if (active && final_done) begin
      nxt_ready = 1'b1; // R04 R23
      if (win_hit(window_ctrl_ff[`FLD_WINDOW_MODE], acc_sum, win_low_ff, win_high_ff)) begin
        nxt_match = 1'b1; // R17 R18
      end
    end
  end

  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      ready_flag_ff <= 1'b0;
      match_flag_ff <= 1'b0;
    end else begin
      ready_flag_ff <= nxt_ready;
      match_flag_ff <= nxt_match;
    end
  end

  // Read multiplexer
  always @* begin
    if (addr_in == `OFS_CONV_MAIN) begin
      nxt_rd_data = conv_main_ff;
    end else if (addr_in == `OFS_ACCUM_CTRL) begin
      nxt_rd_data = accum_ctrl_ff;
    end else if (addr_in == `OFS_REF_CLK_CTRL) begin
      nxt_rd_data = ref_clk_ctrl_ff;
    end else if (addr_in == `OFS_DELAY_CTRL) begin
      nxt_rd_data = delay_ctrl_ff;
    end else if (addr_in == `OFS_WINDOW_CTRL) begin
      nxt_rd_data = window_ctrl_ff;
    end else if (addr_in == `OFS_SAMPLE_LENGTH_CTRL) begin
      nxt_rd_data = sample_length_ctrl_ff;
    end else if (addr_in == `OFS_INPUT_SEL) begin
      nxt_rd_data = input_sel_ff;
    end else if (addr_in == `OFS_COMMAND) begin
      nxt_rd_data = {7'h00, busy_ff}; // R22
    end else if (addr_in == `OFS_FLAGS) begin
      nxt_rd_data = {6'h00, match_flag_ff, ready_flag_ff};
    end else if (addr_in == `OFS_RESULT_LO) begin
      nxt_rd_data = result_ff[7:0];
    end else if (addr_in == `OFS_RESULT_HI) begin
      nxt_rd_data = result_ff[15:8];
    end else if (addr_in == `OFS_WIN_LOW_LO) begin
      nxt_rd_data = win_low_ff[7:0];
    end else if (addr_in == `OFS_WIN_LOW_HI) begin
      nxt_rd_data = win_low_ff[15:8];
    end else if (addr_in == `OFS_WIN_HIGH_LO) begin
      nxt_rd_data = win_high_ff[7:0];
    end else if (addr_in == `OFS_WIN_HIGH_HI) begin
      nxt_rd_data = win_high_ff[15:8];
    end else begin
      nxt_rd_data = 8'h00;
    end
  end

  // Read data for one cycle
  always @(posedge clock_in) begin
    if (!reset_n_in || !rd_en_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= nxt_rd_data;
    end
  end

endmodule // adc_sequencing_control

// >>> bench/core_model.sv
`timescale 1ns/1ps
// Analog core stand-in
module core_model (
  input  wire       clock_in,   // Peripheral clock
  input  wire       start_in,   // Conversion start pulse
  input  wire [3:0] lat_in,     // Answer delay
  input  wire [9:0] value_in,   // Value to return
  output reg        done_out,   // Done pulse
  output reg  [9:0] result_out  // Result with done
);
  integer cnt = 0;
  initial done_out = 1'b0;
  initial result_out = 10'h000;
  // Countdown; result toggles outside done
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    result_out <= ~result_out;
    if (start_in) cnt <= lat_in + 1;
    else if (cnt != 0) cnt <= cnt - 1;
    if (!start_in && cnt == 1) begin
      done_out <= 1'b1;
      result_out <= value_in;
    end
  end
endmodule // core_model

// >>> bench/adc_seq_sva.sv
`timescale 1ns/1ps
// Port-level checks
module adc_seq_sva (
  input wire       clock_in,          // Clock
  input wire       reset_n_in,        // Reset, active low
  input wire [7:0] addr_in,           // Address
  input wire [7:0] wr_data_in,        // Write data
  input wire       wr_en_in,          // Write strobe
  input wire       rd_en_in,          // Read strobe
  input wire       core_done_in,      // Core done
  input wire       converter_on_out,  // Converter on
  input wire       adc_clock_out,     // Converter clock
  input wire       sample_switch_out, // Switch closed
  input wire       convert_start_out, // Start pulse
  input wire [4:0] input_select_out,  // Latched input
  input wire       result_event_out,  // Result pulse
  input wire       result_ready_out,  // Ready flag
  input wire       window_match_out   // Match flag
);
  wire st_wr = wr_en_in && addr_in == 8'h08 && wr_data_in[0];
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Flag clear steps
  sequence s_res_rd;
    rd_en_in && addr_in == 8'h10 ##1 !result_event_out;
  endsequence
  sequence s_w1c;
    wr_en_in && addr_in == 8'h0B && wr_data_in[0] ##1 !result_event_out;
  endsequence
  a_start_after_sample: assert property (convert_start_out |-> $past(sample_switch_out) && !sample_switch_out)
    else $error("start without sampling");
  a_start_one_cycle: assert property (convert_start_out |=> !convert_start_out)
    else $error("start pulse too long");
  a_event_one_cycle: assert property (result_event_out |=> !result_event_out)
    else $error("result pulse too long");
  a_event_sets_flag: assert property (result_event_out |-> result_ready_out)
    else $error("pulse without ready");
  a_flag_needs_event: assert property ($rose(result_ready_out) |-> result_event_out)
    else $error("ready rose without result");
  a_read_clears: assert property (s_res_rd |-> !result_ready_out && !window_match_out)
    else $error("read left a flag set");
  a_w1c_clears: assert property (s_w1c |-> !result_ready_out)
    else $error("W1C left ready set");
  a_off_idle: assert property (!converter_on_out [*2] |-> !sample_switch_out && !adc_clock_out)
    else $error("active while off");
  a_mux_hold: assert property ($changed(input_select_out) |-> $past(core_done_in || st_wr)
    || $past(core_done_in || st_wr, 2))
    else $error("input moved mid conversion");
  a_match_event: assert property ($rose(window_match_out) |-> result_event_out)
    else $error("match rose without result");
endmodule // adc_seq_sva
bind adc_sequencing_control adc_seq_sva u_sva (.clock_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in,
  .rd_en_in, .core_done_in, .converter_on_out, .adc_clock_out, .sample_switch_out, .convert_start_out,
  .input_select_out, .result_event_out, .result_ready_out, .window_match_out);

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// Register-level tests
module tb_top;
  reg        clock_in = 1'b0;
  reg        reset_n_in = 1'b0;
  reg  [7:0] addr_in = 8'h00;
  reg  [7:0] wr_data_in = 8'h00;
  reg        wr_en_in = 1'b0;
  reg        rd_en_in = 1'b0;
  reg        standby_req_in = 1'b0, deep_wake_in = 1'b0;
  reg  [3:0] lat = 4'h1;
  wire [7:0] rd_data_out;
  wire       done, on, sw, cst, ev, rdy, mt, cap;
  wire [9:0] core_res;
  wire [4:0] mux;
  wire [1:0] refs;
  reg [55:0] mk = 56'h1F1F07FF770787;
  reg [15:0] sum;
  integer    error_cnt = 0;
  integer    compares = 0;
  integer    i, n, sw_cyc, st_cnt;
  adc_sequencing_control DUT (.clock_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .standby_req_in, .deep_wake_in, .core_done_in(done), .core_result_in(core_res),
    .converter_on_out(on), .adc_clock_out(), .sample_switch_out(sw), .convert_start_out(cst),
    .input_select_out(mux), .reference_out(refs), .sample_cap_out(cap), .result_event_out(ev),
    .result_ready_out(rdy), .window_match_out(mt));
  core_model model (.clock_in, .start_in(cst), .lat_in(lat), .value_in(10'h2D7), .done_out(done),
    .result_out(core_res));
  // Clock
  initial forever #20 clock_in = ~clock_in;
  // Switch-closed cycle and start pulse counters
  always @(posedge clock_in) begin
    if (sw === 1'b1) sw_cyc <= sw_cyc + 1;
    if (cst === 1'b1) st_cnt <= st_cnt + 1;
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clock_in);
      wr_en_in <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clock_in);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge clock_in);
      rd_en_in <= 1'b0;
      #1 chk(rd_data_out, e);
    end
  endtask
  task go;
    begin
      wr(8'h08, 8'h01);
      sw_cyc = 0;
      st_cnt = 0;
    end
  endtask
  task wait_ev;
    begin
      n = 0;
      while (ev !== 1'b1 && n < 20000) begin
        @(posedge clock_in);
        #1 n = n + 1;
      end
      chk(ev, 1'b1);
    end
  endtask
  task test_done;
    begin
      $display("compares %0d, error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #3000000;
    error_cnt = error_cnt + 1;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 8; i = i + 1) rd(i[7:0], 8'h00);
    for (i = 0; i < 7; i = i + 1) begin
      wr(i[7:0], 8'hFF);
      rd(i[7:0], mk[i*8 +: 8]);
      wr(i[7:0], 8'h00);
    end
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h02, {2'b01, i[1:0], 4'h0});
      chk(refs, i[1:0]);
      chk(cap, 1'b1);
    end
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h01);
    standby_req_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1 chk(on, 1'b0);
    wr(8'h00, 8'h81);
    chk(on, 1'b1);
    standby_req_in <= 1'b0;
    wr(8'h06, 8'h03);
    for (i = 0; i < 2; i = i + 1) begin
      lat <= i[0] ? 4'h1 : 4'h8;
      wr(8'h05, {3'h0, {5{i[0]}}});
      wr(8'h00, {5'h00, i[0], 2'b01});
      go;
      rd(8'h08, 8'h01);
      wr(8'h06, 8'h09);
      chk(mux, i[0] ? 5'h09 : 5'h03);
      wait_ev;
      rd(8'h08, 8'h00);
      chk(sw_cyc >= 3 + 62 * i && sw_cyc <= 5 + 62 * i, 1'b1);
      rd(8'h10, i[0] ? 8'hB5 : 8'hD7);
      rd(8'h11, i[0] ? 8'h00 : 8'h02);
    end
    wr(8'h05, 8'h00);
    wr(8'h00, 8'h01);
    for (i = 0; i < 7; i = i + 1) begin
      wr(8'h01, i[7:0]);
      wr(8'h03, 8'h1F);
      go;
      wait_ev;
      sum = 16'h02D7 << i;
      chk(st_cnt, 16'h0001 << i);
      rd(8'h10, sum[7:0]);
      rd(8'h11, sum[15:8]);
      rd(8'h03, 8'h10 | ((15 + (1 << i)) & 15));
    end
    wr(8'h01, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h01);
    wr(8'h14, 8'hD6);
    wr(8'h15, 8'h02);
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h04, i[7:0]);
      go;
      wait_ev;
      rd(8'h0B, {6'h00, i == 2 || i == 4, 1'b1});
      wr(8'h0B, 8'h00);
      rd(8'h0B, {6'h00, i == 2 || i == 4, 1'b1});
      wr(8'h0B, 8'h03);
      rd(8'h0B, 8'h00);
    end
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h03);
    go;
    wait_ev;
    #40;
    wait_ev;
    rd(8'h08, 8'h01);
    wr(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    chk(on, 1'b0);
    wr(8'h03, 8'h20);
    for (i = 0; i < 2; i = i + 1) begin
      deep_wake_in <= i[0];
      wr(8'h00, 8'h01);
      go;
      n = 0;
      while (sw !== 1'b1 && n < 1000) begin
        @(posedge clock_in);
        #1 n = n + 1;
      end
      chk(n >= 31 && n <= 35, 1'b1);
      wait_ev;
    end
    test_done;
  end
endmodule // tb_top
